// *** hpsc_port.sv ***
`timescale 1ns/1ps
// Behaviour
// - Ownership clears on configured rise; held one while configured is zero.
// - Software sets ownership for non-high-speed devices; companion then owns.
// - Without power switch capability port power reads one, ignores writes.
// - With capability, port power is read/write switch setting.
// - Unpowered port is inert: no connect, enable reads zero.
// - Over-current on powered switched port drops port power.
// - Line state mirrors D+ upper, D- lower bit.
// - Writing reset one from zero starts bus reset; zero ends it once HPSC_RST_CYC cycles have elapsed.
// - Suspended port blocks downstream data except reset; resume sensed.
// - Port state decoded from enable and suspend bits.
// - Over-current change set on any over-current change; write-one clears.
// - Over-current active follows present condition.
// - Enable change set only on EOF2 fault disable; write-one clears.
// - Software cannot enable; reset finding high speed enables.
// - Connect reads device presence, zero without power.
module hpsc_port
  import hpsc_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // port side pins
  input wire hpsc_pkg::hpsc_line_t line_i,
  output logic port_power_o,
  output logic bus_reset_o,
  output logic drive_resume_o,
  output logic downstream_block_o,
  output logic companion_ownership_o,
  output hpsc_pkg::hpsc_port_state_t port_state_o,
  // interrupt
  output logic irq_o
);
  import hpsc_pkg::*;

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  hpsc_bus_req_t req;
  hpsc_line_t ln;
  logic configured_flag_q;
  logic power_switch_capability_q;
  logic cfg_prev_q;
  logic companion_ownership_q;
  logic port_power_q;
  logic port_enabled_flag_q;
  logic port_sleep_state_q;
  logic force_wakeup_q;
  logic port_bus_reset_q;
  logic overcurrent_prev_q;
  logic ovc_change_q;
  logic enable_change_flag_q;
  logic [HPSC_RSTCNT_W-1:0] rst_cnt_q;
  logic [HPSC_IRQ_W-1:0] irq_stat_q;
  logic [HPSC_IRQ_W-1:0] irq_mask_q;
  logic [31:0] rdata_q;

  assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  hpsc_sync #(.W(7)) u_sync (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .async_i(line_i),
    .sync_o(ln)
  );

  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  wire sel_sc = req.addr == HPSC_PORT_SC_ADDR;
  wire sel_ctrl = req.addr == HPSC_CTRL_ADDR;
  wire sel_stat = req.addr == HPSC_IRQ_STAT_ADDR;
  wire sel_mask = req.addr == HPSC_IRQ_MASK_ADDR;
  wire wr_sc = req.wr && sel_sc;
  wire wr_ctrl = req.wr && sel_ctrl;
  wire rd_stat = req.rd && sel_stat;

  wire pp_eff = power_switch_capability_q ? port_power_q : 1'b1;

  wire connect_present = pp_eff & ln.present;
  wire overcurrent_active = ln.overcurrent;
  wire [1:0] line_state_field = pp_eff ? {ln.dp, ln.dm} : 2'h0;

  wire cfg_rise = configured_flag_q & ~cfg_prev_q;
  wire cfg_next = wr_ctrl ? req.wdata[HPSC_B_CFG] : configured_flag_q;
  wire oc_edge = overcurrent_active ^ overcurrent_prev_q;
  wire pr_start = wr_sc & req.wdata[HPSC_B_PR] & ~port_bus_reset_q;
  wire rst_timed = rst_cnt_q >= HPSC_RSTCNT_W'(HPSC_RST_CYC);
  wire pr_end = port_bus_reset_q & wr_sc & ~req.wdata[HPSC_B_PR] &
                rst_timed;
  wire eof2_dis = port_enabled_flag_q & ln.eof2_fault & pp_eff;
  wire resume_seen = port_sleep_state_q & ln.resume_k;

  // ----------------------------------------------------------------------
  // ownership and config
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      configured_flag_q <= HPSC_CTRL_RST[HPSC_B_CFG];
      power_switch_capability_q <= HPSC_CTRL_RST[HPSC_B_PPC];
      cfg_prev_q <= HPSC_CTRL_RST[HPSC_B_CFG];
      companion_ownership_q <= HPSC_PO_RST;
    end else begin
      cfg_prev_q <= configured_flag_q;
      if (wr_ctrl) begin
        configured_flag_q <= req.wdata[HPSC_B_CFG];
        power_switch_capability_q <= req.wdata[HPSC_B_PPC];
      end
      if (!cfg_next) begin
        companion_ownership_q <= 1'b1;
      end else if (cfg_rise) begin
        companion_ownership_q <= 1'b0;
      end else if (wr_sc) begin
        companion_ownership_q <= req.wdata[HPSC_B_PO];
      end
    end
  end

  // ----------------------------------------------------------------------
  // power, reset, enable, suspend
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      port_power_q <= HPSC_PP_RST;
      port_bus_reset_q <= 1'b0;
      rst_cnt_q <= '0;
      port_enabled_flag_q <= 1'b0;
      port_sleep_state_q <= 1'b0;
      force_wakeup_q <= 1'b0;
    end else begin
      if (power_switch_capability_q && port_power_q && ln.overcurrent) begin
        port_power_q <= 1'b0;
      end else if (wr_sc && power_switch_capability_q) begin
        port_power_q <= req.wdata[HPSC_B_PP];
      end
      if (port_bus_reset_q && !rst_timed) begin
        rst_cnt_q <= rst_cnt_q + 1'b1;
      end else if (!port_bus_reset_q) begin
        rst_cnt_q <= '0;
      end
      if (!pp_eff || companion_ownership_q) begin
        port_bus_reset_q <= 1'b0;
        port_enabled_flag_q <= 1'b0;
        port_sleep_state_q <= 1'b0;
        force_wakeup_q <= 1'b0;
      end else if (pr_start || (port_bus_reset_q && !pr_end)) begin
        port_bus_reset_q <= 1'b1;
        port_enabled_flag_q <= 1'b0;
        port_sleep_state_q <= 1'b0;
        force_wakeup_q <= 1'b0;
      end else if (pr_end) begin
        port_bus_reset_q <= 1'b0;
        port_enabled_flag_q <= ln.present & ln.high_speed;
      end else begin
        if (eof2_dis || (wr_sc && !req.wdata[HPSC_B_PE])) begin
          port_enabled_flag_q <= 1'b0;
          port_sleep_state_q <= 1'b0;
        end else if (wr_sc && req.wdata[HPSC_B_SUS] &&
                     port_enabled_flag_q) begin
          port_sleep_state_q <= 1'b1;
        end
        if (resume_seen) begin
          force_wakeup_q <= 1'b1;
        end else if (wr_sc && port_sleep_state_q) begin
          force_wakeup_q <= req.wdata[HPSC_B_FPR];
          if (!req.wdata[HPSC_B_FPR] && force_wakeup_q) begin
            port_sleep_state_q <= 1'b0;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // change flags
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      overcurrent_prev_q <= 1'b0;
      ovc_change_q <= 1'b0;
      enable_change_flag_q <= 1'b0;
    end else begin
      overcurrent_prev_q <= overcurrent_active;
      if (oc_edge) begin
        ovc_change_q <= 1'b1;
      end else if (wr_sc && req.wdata[HPSC_B_OCC]) begin
        ovc_change_q <= 1'b0;
      end
      if (!pp_eff) begin
        enable_change_flag_q <= 1'b0;
      end else if (eof2_dis) begin
        enable_change_flag_q <= 1'b1;
      end else if (wr_sc && req.wdata[HPSC_B_PEC]) begin
        enable_change_flag_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------------
  wire [HPSC_IRQ_W-1:0] irq_ev = {resume_seen, pr_end, eof2_dis, oc_edge};

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_stat_q <= '0;
      irq_mask_q <= HPSC_MASK_RST;
    end else begin
      irq_stat_q <= irq_ev | (rd_stat ? '0 : irq_stat_q);
      if (req.wr && sel_mask) begin
        irq_mask_q <= req.wdata[HPSC_IRQ_W-1:0];
      end
    end
  end

  assign irq_o = |(irq_stat_q & irq_mask_q);

  // ----------------------------------------------------------------------
  // read back
  // ----------------------------------------------------------------------
  // state decode
  assign port_state_o = !port_enabled_flag_q ? HPSC_PORT_DISABLED :
                        port_sleep_state_q ? HPSC_PORT_SUSPENDED :
                        HPSC_PORT_ENABLED;

  logic [31:0] sc_word;
  always_comb begin
    sc_word = '0;
    sc_word[HPSC_B_CC] = connect_present;
    sc_word[HPSC_B_PE] = port_enabled_flag_q & pp_eff;
    sc_word[HPSC_B_PEC] = enable_change_flag_q;
    sc_word[HPSC_B_OC] = overcurrent_active;
    sc_word[HPSC_B_OCC] = ovc_change_q;
    sc_word[HPSC_B_FPR] = force_wakeup_q;
    sc_word[HPSC_B_SUS] = port_sleep_state_q;
    sc_word[HPSC_B_PR] = port_bus_reset_q;
    sc_word[HPSC_B_LS_HI:HPSC_B_LS_LO] = line_state_field;
    sc_word[HPSC_B_PP] = pp_eff;
    sc_word[HPSC_B_PO] = companion_ownership_q;
  end

  wire [31:0] ctrl_word = {30'h0, power_switch_capability_q,
                           configured_flag_q};
  wire [31:0] rd_mux = sel_sc ? sc_word :
                       sel_ctrl ? ctrl_word :
                       sel_stat ? {28'h0, irq_stat_q} :
                       sel_mask ? {28'h0, irq_mask_q} :
                       HPSC_UNMAPPED_RD;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= req.rd ? rd_mux : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign rdata_o = rdata_q;
  assign port_power_o = pp_eff;
  assign bus_reset_o = port_bus_reset_q;
  assign drive_resume_o = force_wakeup_q & port_sleep_state_q;
  assign downstream_block_o = port_sleep_state_q & ~port_bus_reset_q;
  assign companion_ownership_o = companion_ownership_q;

endmodule

// *** hpsc_pkg.sv ***
package hpsc_pkg;

  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] HPSC_PORT_SC_ADDR = 8'h00;
  localparam logic [7:0] HPSC_CTRL_ADDR = 8'h04;
  localparam logic [7:0] HPSC_IRQ_STAT_ADDR = 8'h08;
  localparam logic [7:0] HPSC_IRQ_MASK_ADDR = 8'h0C;
  localparam logic [31:0] HPSC_UNMAPPED_RD = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // port status/control field positions
  // ----------------------------------------------------------------------
  localparam int HPSC_B_CC = 0;
  localparam int HPSC_B_PE = 2;
  localparam int HPSC_B_PEC = 3;
  localparam int HPSC_B_OC = 4;
  localparam int HPSC_B_OCC = 5;
  localparam int HPSC_B_FPR = 6;
  localparam int HPSC_B_SUS = 7;
  localparam int HPSC_B_PR = 8;
  localparam int HPSC_B_LS_LO = 10;
  localparam int HPSC_B_LS_HI = 11;
  localparam int HPSC_B_PP = 12;
  localparam int HPSC_B_PO = 13;

  // control register fields (configured flag, power switch capability)
  localparam int HPSC_B_CFG = 0;
  localparam int HPSC_B_PPC = 1;

  // interrupt status/mask bits
  localparam int HPSC_I_OCC = 0;
  localparam int HPSC_I_PEC = 1;
  localparam int HPSC_I_RST_DONE = 2;
  localparam int HPSC_I_RESUME = 3;
  localparam int HPSC_IRQ_W = 4;

  // reset values
  localparam logic HPSC_PO_RST = 1'b1;
  localparam logic HPSC_PP_RST = 1'b0;
  localparam logic [1:0] HPSC_CTRL_RST = 2'h0;
  localparam logic [3:0] HPSC_MASK_RST = 4'h0;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int HPSC_CLK_MHZ = 40;
  localparam int HPSC_RST_MIN_US = 10;
  localparam int HPSC_RST_CYC = HPSC_RST_MIN_US * HPSC_CLK_MHZ;
  localparam int HPSC_RSTCNT_W = 16;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    HPSC_PORT_DISABLED,
    HPSC_PORT_ENABLED,
    HPSC_PORT_SUSPENDED
  } hpsc_port_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } hpsc_bus_req_t;

  typedef struct packed {
    logic dp;
    logic dm;
    logic present;
    logic overcurrent;
    logic high_speed;
    logic eof2_fault;
    logic resume_k;
  } hpsc_line_t;

endpackage

// *** hpsc_sync.sv ***
`timescale 1ns/1ps
module hpsc_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // data
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // ----------------------------------------------------------------------
  // three stages, accepted when stages two and three agree
  // ----------------------------------------------------------------------
  wire [W-1:0] agree = ~(s2_q ^ s3_q);

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      sync_o <= '0;
    end else begin
      s1_q <= async_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      sync_o <= (agree & s3_q) | (~agree & sync_o);
    end
  end

endmodule

// *** hpsc_port_sva.sv ***
`timescale 1ns/1ps
module hpsc_port_sva
  import hpsc_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  // port side
  input wire hpsc_pkg::hpsc_line_t line_i,
  input wire logic port_power_o,
  input wire logic bus_reset_o,
  input wire logic drive_resume_o,
  input wire logic downstream_block_o,
  input wire logic companion_ownership_o,
  input wire hpsc_pkg::hpsc_port_state_t port_state_o,
  input wire logic irq_o
);
  // ----------
  // properties
  // ----------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_rd_sc;
    rd_i && addr_i == HPSC_PORT_SC_ADDR;
  endsequence
  sequence s_rst_go;
    wr_i && addr_i == HPSC_PORT_SC_ADDR && wdata_i[HPSC_B_PR] &&
      !wdata_i[HPSC_B_PO] && !bus_reset_o && port_power_o &&
      !companion_ownership_o;
  endsequence
  sequence s_unpowered;
    !port_power_o ##1 !port_power_o;
  endsequence
  property p_rsvd;
    s_rd_sc |=> rdata_o[31:14] == 18'h0 && !rdata_o[9] && !rdata_o[1];
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
  property p_state;
    s_rd_sc |=> rdata_o[HPSC_B_PE] == ($past(port_state_o) != 2'h0) &&
      (rdata_o[HPSC_B_PE] && rdata_o[HPSC_B_SUS]) ==
      ($past(port_state_o) == HPSC_PORT_SUSPENDED);
  endproperty
  a_state: assert property (p_state) else $error("state decode");
  property p_cfg_off;
    wr_i && addr_i == HPSC_CTRL_ADDR && !wdata_i[HPSC_B_CFG]
      |=> companion_ownership_o;
  endproperty
  a_cfg_off: assert property (p_cfg_off) else $error("owner not 1");
  property p_ppc_off;
    wr_i && addr_i == HPSC_CTRL_ADDR && !wdata_i[HPSC_B_PPC] |=> port_power_o;
  endproperty
  a_ppc_off: assert property (p_ppc_off) else $error("power not 1");
  property p_en_src;
    $past(port_state_o) == HPSC_PORT_DISABLED &&
      port_state_o == HPSC_PORT_ENABLED |-> $past(bus_reset_o);
  endproperty
  a_en_src: assert property (p_en_src) else $error("enable no reset");
  property p_block;
    downstream_block_o == (port_state_o == HPSC_PORT_SUSPENDED && !bus_reset_o);
  endproperty
  a_block: assert property (p_block) else $error("block level");
  property p_unpw;
    s_unpowered |-> port_state_o == HPSC_PORT_DISABLED && !bus_reset_o;
  endproperty
  a_unpw: assert property (p_unpw) else $error("unpowered active");
  property p_rst_go;
    s_rst_go |=> bus_reset_o [*8];
  endproperty
  a_rst_go: assert property (p_rst_go) else $error("no bus reset");
endmodule

bind hpsc_port hpsc_port_sva chk_u (.clk_i(clk_i), .reset_n_i(reset_n_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .line_i(line_i), .port_power_o(port_power_o),
  .bus_reset_o(bus_reset_o), .drive_resume_o(drive_resume_o),
  .downstream_block_o(downstream_block_o),
  .companion_ownership_o(companion_ownership_o),
  .port_state_o(port_state_o), .irq_o(irq_o));

// *** hpsc_usb_dev.sv ***
`timescale 1ns/1ps
module hpsc_usb_dev
  import hpsc_pkg::*;
(
  // commands
  input wire logic attach_i,
  input wire logic low_speed_i,
  input wire logic oc_i,
  input wire logic eof2_i,
  input wire logic resume_i,
  // host side
  input wire logic port_power_i,
  input wire logic bus_reset_i,
  output hpsc_pkg::hpsc_line_t line_o
);
  // ----------
  // line model
  // ----------
  wire present = attach_i && port_power_i;
  // se0 via pulldowns, low speed idles k
  wire [1:0] lvl = !present || bus_reset_i ? 2'h0 :
    resume_i || low_speed_i ? 2'h1 : 2'h2;
  assign line_o = '{dp: lvl[1], dm: lvl[0], present: present,
    overcurrent: oc_i, high_speed: present && !low_speed_i,
    eof2_fault: eof2_i, resume_k: resume_i};
endmodule

// *** hpsc_port_tb_top.sv ***
`timescale 1ns/1ps
module hpsc_port_tb_top;
  import hpsc_pkg::*;
  // ----------
  // signals
  // ----------
  localparam logic [7:0] SC = HPSC_PORT_SC_ADDR;
  localparam logic [7:0] CT = HPSC_CTRL_ADDR;
  localparam logic [31:0] PPB = 32'h0000_1000;
  localparam logic [31:0] PEB = 32'h0000_0004;
  localparam logic [31:0] SUSB = 32'h0000_0080;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0000_0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rdata_o, v;
  hpsc_line_t line_i;
  hpsc_port_state_t port_state_o;
  logic port_power_o, bus_reset_o, drive_resume_o, downstream_block_o;
  logic companion_ownership_o, irq_o;
  logic att = 1'b0, lsd = 1'b0, oc_c = 1'b0, eof = 1'b0, res = 1'b0;
  bit po, pp, pr, port_sleep_state, pe, enable_change_flag, oc, occ, cc, force_wakeup;
  bit [1:0] ls;
  bit [3:0] ist;
  int error_cnt = 0, check_count = 0, seed = 78;
  always #12.5 clk_i = ~clk_i;
  hpsc_port dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .line_i(line_i), .port_power_o(port_power_o),
    .bus_reset_o(bus_reset_o), .drive_resume_o(drive_resume_o),
    .downstream_block_o(downstream_block_o),
    .companion_ownership_o(companion_ownership_o),
    .port_state_o(port_state_o), .irq_o(irq_o));
  hpsc_usb_dev dev_u (.attach_i(att), .low_speed_i(lsd), .oc_i(oc_c),
    .eof2_i(eof), .resume_i(res), .port_power_i(port_power_o),
    .bus_reset_i(bus_reset_o), .line_o(line_i));
  // ----------
  // tasks
  // ----------
  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic idle(int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask
  task automatic csc();
    rd(SC);
    chk("port_sc", {18'h0, po, pp, ls, 1'b0, pr, port_sleep_state, force_wakeup, occ, oc, enable_change_flag,
      pe, 1'b0, cc}, v);
  endtask
  task automatic wsc(logic [31:0] x);
    wr(SC, x | (po ? 32'h0000_2000 : 32'h0) | (pp ? PPB : 32'h0));
  endtask
  task automatic do_rst();
    wsc(32'h0000_0100);
    {pr, ls} = 3'h4;
    idle(4);
    chk("bus_reset_o", 1, bus_reset_o);
    wsc(32'h0);
    csc();
    idle(400);
    wsc(PEB);
    {pr, pe, ls, ist[2]} = 5'h0D;
    idle(6);
    csc();
  endtask
  // ----------
  // sequence
  // ----------
  initial begin
    #250000;
    error_cnt++;
    complete_run();
  end
  initial begin
    idle(12);
    reset_n_i <= 1'b1;
    {po, pp} = 2'h3;
    csc();
    rd(8'h10);
    chk("unmapped", 32'h0, v);
    wr(SC, $random(seed) & 32'hFFFF_C200);
    csc();
    wr(CT, 32'h1);
    po = 1'b0;
    idle(2);
    chk("owner", 0, companion_ownership_o);
    wr(CT, 32'h3);
    pp = 1'b0;
    att <= 1'b1;
    idle(8);
    csc();
    pp = 1'b1;
    wsc(32'h0);
    {cc, ls} = 3'h6;
    idle(8);
    csc();
    wsc(PEB);
    csc();
    do_rst();
    chk("port_state_o", HPSC_PORT_ENABLED, port_state_o);
    eof <= 1'b1;
    idle(8);
    eof <= 1'b0;
    {pe, enable_change_flag, ist[1]} = 3'h3;
    idle(6);
    csc();
    wsc(32'h0);
    csc();
    wsc(32'h8);
    enable_change_flag = 1'b0;
    csc();
    do_rst();
    wsc(PEB | SUSB);
    port_sleep_state = 1'b1;
    idle(2);
    chk("port_state_o", HPSC_PORT_SUSPENDED, port_state_o);
    chk("block", 1, downstream_block_o);
    res <= 1'b1;
    {ls, ist[3], force_wakeup} = 4'h7;
    idle(8);
    csc();
    res <= 1'b0;
    ls = 2'h2;
    wsc(PEB | SUSB | 32'h40);
    idle(2);
    chk("drive_resume_o", 1, drive_resume_o);
    idle(4);
    wsc(PEB | SUSB);
    {port_sleep_state, force_wakeup} = 2'h0;
    idle(2);
    chk("port_state_o", HPSC_PORT_ENABLED, port_state_o);
    chk("drive_resume_o", 0, drive_resume_o);
    csc();
    oc_c <= 1'b1;
    idle(8);
    {oc, occ, pp, pe, port_sleep_state, cc, ls, ist[0], force_wakeup} = 10'h302;
    csc();
    wsc(32'h20);
    occ = 1'b0;
    csc();
    oc_c <= 1'b0;
    idle(8);
    {oc, occ} = 2'h1;
    csc();
    chk("irq_o", 0, irq_o);
    wr(8'h0C, 32'hF);
    idle(1);
    chk("irq_o", 1, irq_o);
    rd(8'h08);
    chk("irq_stat", {28'h0, ist}, v);
    idle(2);
    chk("irq_o", 0, irq_o);
    wr(CT, 32'h2);
    po = 1'b1;
    idle(2);
    chk("owner", 1, companion_ownership_o);
    wr(CT, 32'h3);
    po = 1'b0;
    idle(2);
    chk("owner", 0, companion_ownership_o);
    lsd <= 1'b1;
    pp = 1'b1;
    wsc(32'h0);
    {cc, ls} = 3'h5;
    idle(8);
    csc();
    po = 1'b1;
    wsc(32'h0);
    idle(2);
    chk("owner", 1, companion_ownership_o);
    complete_run();
  end
endmodule
